//--- bench/lrmd_top_tb.sv
// self-checking bench for the legacy region map decode block
`timescale 1ns/1ns
module lrmd_top_tb;
   import lrmd_pkg::*;
   logic SYS_CLK = 1'b0;
   logic RST_N = 1'b0;
   logic REG_SEL = 1'b0, REG_WRITE = 1'b0, ACC_VALID = 1'b0;
   logic [15:0] REG_ADDR = 16'h0000;
   logic [31:0] REG_WDATA = 32'h0000_0000, REG_RDATA;
   logic REG_HIT, RT_VALID, XB_START, XB_SRC_GFX, XB_TAKE, XB_DATA_DRIVE, XB_RDY, strb;
   lrmd_acc_t ACC = '0;
   lrmd_route_t RT;
   logic [3:0] RT_FIELD, fl, p_n = 4'h0, p_idle = 4'h0;
   logic go = 1'b0, p_src = 1'b0, p_done, lm, w, prev_drive = 1'b0;
   logic exp_nw = 1'b0, exp_pd = 1'b0, b2b = 1'b0, have_strb = 1'b0;
   int err_count = 0, check_count = 0, cyc = 0, t_take = 0, t_strb = 0, n_strb = 0;

   always #4 SYS_CLK = ~SYS_CLK;

   lrmd_top i_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_SEL(REG_SEL),
      .REG_WRITE(REG_WRITE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_RDATA(REG_RDATA), .REG_HIT(REG_HIT), .ACC_VALID(ACC_VALID), .ACC(ACC),
      .RT_VALID(RT_VALID), .RT(RT), .RT_FIELD(RT_FIELD), .XB_START(XB_START),
      .XB_SRC_GFX(XB_SRC_GFX), .XB_TAKE(XB_TAKE), .XB_DATA_DRIVE(XB_DATA_DRIVE),
      .INTERNAL_DATA_STROBE(strb), .XB_RDY(XB_RDY));

   lrmd_xbus_partner i_far (.clk(SYS_CLK), .go(go), .count(p_n), .idle(p_idle),
      .src(p_src), .take(XB_TAKE), .start(XB_START), .src_gfx(XB_SRC_GFX),
      .done(p_done));

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED %s exp=%h seen=%h", n, e, s);
      end
   endtask : chk

   task automatic chk1(input string n, input logic s, input logic e);
      chk(n, {31'b0, s}, {31'b0, e});
   endtask : chk1

   task automatic summarize();
      $display("checks=%0d mismatches=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : summarize

   // ------------------------------------------------------------------
   // register port and access lookup
   // ------------------------------------------------------------------
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge SYS_CLK);
      #1;
      {REG_SEL, REG_WRITE, REG_ADDR, REG_WDATA} = {2'b11, a, d};
      @(posedge SYS_CLK);
      #1;
      REG_SEL = 1'b0;
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic h);
      @(posedge SYS_CLK);
      #1;
      {REG_SEL, REG_WRITE, REG_ADDR} = {2'b10, a};
      @(posedge SYS_CLK);
      #1;
      REG_SEL = 1'b0;
      chk("rdata", REG_RDATA, e);
      chk1("hit", REG_HIT, h);
   endtask : rd

   task automatic acc(input logic wv, input logic p, input logic h, input logic [19:0] a);
      @(posedge SYS_CLK);
      #1;
      ACC_VALID = 1'b1;
      ACC = '{write: wv, from_pci: p, cache_hit: h, addr: a};
      @(posedge SYS_CLK);
      #1;
      ACC_VALID = 1'b0;
      chk1("rt_valid", RT_VALID, 1'b1);
   endtask : acc

   // ------------------------------------------------------------------
   // internal-bus monitor
   // ------------------------------------------------------------------
   always @(posedge SYS_CLK) begin
      if (RST_N) begin
         if (strb === 1'b1) begin
            chk1("rdy", XB_RDY, 1'b1);
            chk1("drive", XB_DATA_DRIVE, 1'b1);
            chk("latency", 32'(cyc - t_take), exp_nw ? 32'd1 : 32'd2);
            if (!exp_nw)
               chk1("early drive", prev_drive, 1'b1);
            t_strb = cyc;
            have_strb = 1'b1;
            n_strb++;
         end
         if (XB_TAKE === 1'b1) begin
            if (b2b && have_strb)
               chk("overlap", 32'(cyc - t_strb), exp_pd ? 32'd1 : 32'd0);
            t_take = cyc;
         end
         prev_drive = XB_DATA_DRIVE;
         cyc++;
      end
   end

   task automatic xrun(input logic s, input logic [3:0] n, input logic [3:0] idl);
      {p_src, p_n, p_idle, b2b, have_strb, n_strb} = {s, n, idl, idl == 4'h0, 1'b0, 32'd0};
      @(posedge SYS_CLK);
      #1;
      go = 1'b1;
      @(posedge SYS_CLK);
      #1;
      go = 1'b0;
      @(posedge SYS_CLK);
      for (int k = 0; k < 100 && !p_done; k++)
         @(posedge SYS_CLK);
      repeat (4) @(posedge SYS_CLK);
      chk("strobes", n_strb, 32'(n));
   endtask : xrun

   initial begin
      repeat (20000) @(posedge SYS_CLK);
      err_count++;
      summarize();
   end

   initial begin
      repeat (6) @(posedge SYS_CLK);
      #1;
      RST_N = 1'b1;
      rd(LRMD_OFF_MAP_AB, LRMD_RST_MAP_AB, 1'b1);
      rd(LRMD_OFF_MAP_CD, LRMD_RST_MAP_CD, 1'b1);
      rd(LRMD_OFF_MAP_EF, LRMD_RST_MAP_EF, 1'b1);
      wr(LRMD_OFF_MAP_AB, 32'hffff_ffff);
      rd(LRMD_OFF_MAP_AB, 32'h1f7f_e0ff, 1'b1);
      wr(LRMD_OFF_MAP_CD, 32'h7654_3210);
      wr(LRMD_OFF_MAP_EF, 32'hfedc_ba98);
      wr(16'h8010, 32'h1234_5678);
      rd(16'h8010, 32'h0000_0000, 1'b0);
      rd(LRMD_OFF_MAP_CD, 32'h7654_3210, 1'b1);
      rd(LRMD_OFF_MAP_EF, 32'hfedc_ba98, 1'b1);
      // one lookup per 16 KB region of C0000h..FFFFFh
      for (int i = 0; i < 16; i++) begin
         acc(1'b0, 1'b0, 1'b0, 20'(32'hc_0000 + i * 32'h4000));
         chk("field", {28'b0, RT_FIELD}, 32'(i));
         chk1("in_window", RT.in_window, 1'b1);
      end
      acc(1'b0, 1'b0, 1'b0, 20'h1_0000);
      chk("low field", {28'b0, RT_FIELD}, 32'd0);
      chk1("low window", RT.in_window, 1'b0);
      // graphics steering for every enable combination
      for (int g = 0; g < 8; g++) begin
         wr(LRMD_OFF_MAP_AB, {3'b0, g[2], 4'h6, 3'b0, g[1], 4'h5, 11'h0, g[0], 4'h3});
         acc(1'b1, 1'b0, 1'b0, 20'ha_c000);
         chk1("gfx a", RT.to_gfx, g[0]);
         chk("field a", {28'b0, RT_FIELD}, 32'd3);
         acc(1'b0, 1'b0, 1'b0, 20'hb_4000);
         chk1("gfx b0", RT.to_gfx, g[1]);
         chk("field b0", {28'b0, RT_FIELD}, 32'd5);
         acc(1'b0, 1'b1, 1'b0, 20'hb_8000);
         chk1("gfx b8", RT.to_gfx, g[2]);
         chk("field b8", {28'b0, RT_FIELD}, 32'd6);
      end
      // every control field value against every access kind
      for (int f = 0; f < 16; f++) begin
         wr(LRMD_OFF_MAP_CD, {28'h000_0000, 4'(f)});
         fl = 4'(f);
         for (int k = 0; k < 8; k++) begin
            w = k[0];
            acc(w, k[1], k[2], 20'hc_1234);
            lm = w ? fl[1] : fl[0];
            if (k[1]) begin
               chk1("pci local", RT.local_mem, fl[3] & lm);
               chk1("pci deny", RT.pci_denied, ~(fl[3] & lm));
            end else begin
               chk1("local", RT.local_mem, lm);
               chk1("to master", RT.to_pci_master, ~lm);
               chk1("cacheable", RT.cacheable, fl[2]);
               chk1("cache upd", RT.cache_update, w & fl[2] & k[2]);
            end
         end
      end
      // internal-bus timing in every mode, prompt and slow requester
      for (int m = 0; m < 16; m++) begin
         wr(LRMD_OFF_MAP_AB, {24'h0, m[2], m[1], m[0], 5'h0});
         exp_pd = m[2];
         exp_nw = m[3] ? m[1] : m[0];
         xrun(m[3], 4'h3, 4'h0);
         xrun(m[3], 4'h2, 4'h2);
      end
      summarize();
   end
endmodule : lrmd_top_tb

//--- bench/lrmd_xbus_partner.sv
// internal-bus requester model standing for core, graphics pipe and bridge
`timescale 1ns/1ns
module lrmd_xbus_partner
   import lrmd_pkg::*;
(
   input wire logic clk,
   input wire logic go,
   input wire logic [3:0] count,
   input wire logic [3:0] idle,
   input wire logic src,
   input wire logic take,
   output logic start,
   output logic src_gfx,
   output logic done
);
   initial begin
      start = 1'b0;
      src_gfx = 1'b0;
      done = 1'b1;
      forever begin
         @(posedge clk iff go);
         #1;
         done = 1'b0;
         for (int i = 0; i < count; i++) begin
            // slow mode: released qualifier shows the inverse meanwhile
            if (i > 0 && idle > 0) begin
               start = 1'b0;
               src_gfx = ~src;
               repeat (idle) begin
                  @(posedge clk);
                  #1;
               end
            end
            start = 1'b1;
            src_gfx = src;
            // request held until accepted at a rising edge
            @(posedge clk iff take);
            #1;
         end
         start = 1'b0;
         src_gfx = ~src;
         done = 1'b1;
      end
   end
endmodule : lrmd_xbus_partner

//--- src/lrmd_pkg.sv
// constants, field layout and carrier types for the legacy region map decode
// ------------------------------------------------------------------
// Operation
// - pipeline-disable bit 7 clear lets next address overlap current data phase.
// - graphics no-wait bit 6: data one clock early, or with ready.
// - bus-unit no-wait bit 5: data one clock early, or with ready.
// - A-region graphics enable bit 4 steers A0000h-AFFFFh to graphics.
// - A/B map bits 3:0 control the A0000h region, common decode.
// - C/D map holds eight fields, C0000h at 3:0 up to DC000h at 31:28.
// - E/F map holds eight fields, E0000h at 3:0 up to FC000h at 31:28.
// - PCI slave access needs control bit 3 and matching read/write enable.
// - region with control bit 2 clear is never cached.
// - bit 1 set allows local writes, clear forwards writes to PCI master.
// - bit 0 set allows local reads, clear forwards reads to PCI master.
// - cached writes update the cache before the write permission check.
// - A/B map holds B8000h field at 27:24 and B0000h at 19:16.
// - graphics enables bit 20 and bit 28 steer B0000h and B8000h halves.
// ------------------------------------------------------------------
package lrmd_pkg;
   localparam logic [15:0] LRMD_OFF_MAP_AB = 16'h8004;
   localparam logic [15:0] LRMD_OFF_MAP_CD = 16'h8008;
   localparam logic [15:0] LRMD_OFF_MAP_EF = 16'h800c;
   localparam logic [31:0] LRMD_RST_MAP_AB = 32'h0000_0000;
   localparam logic [31:0] LRMD_RST_MAP_CD = 32'h0000_0000;
   localparam logic [31:0] LRMD_RST_MAP_EF = 32'h0000_0000;
   // reserved bits 31:29, 23, 12:8 read as zero
   localparam logic [31:0] LRMD_MASK_MAP_AB = 32'h1f7f_e0ff;
   localparam int LRMD_BIT_PIPE_DIS = 7;
   localparam int LRMD_BIT_GFX_NW = 6;
   localparam int LRMD_BIT_BIU_NW = 5;
   localparam int LRMD_BIT_GFX_A = 4;
   localparam int LRMD_BIT_GFX_B_LOW = 20;
   localparam int LRMD_BIT_GFX_B_HIGH = 28;
   localparam int LRMD_LSB_CTL_A = 0;
   localparam int LRMD_LSB_CTL_B_LOW = 16;
   localparam int LRMD_LSB_CTL_B_HIGH = 24;
   localparam int LRMD_FIELD_W = 4;
   localparam int LRMD_FIELDS_PER_REG = 8;
   // region control field bits
   localparam int LRMD_CTL_PCI = 3;
   localparam int LRMD_CTL_CACHE = 2;
   localparam int LRMD_CTL_WR = 1;
   localparam int LRMD_CTL_RD = 0;
   // 16 KB region indexes taken from address bits 19:14
   localparam int LRMD_IDX_LSB = 14;
   localparam logic [5:0] LRMD_IDX_A = 6'h28;
   localparam logic [5:0] LRMD_IDX_B_LOW = 6'h2c;
   localparam logic [5:0] LRMD_IDX_B_HIGH = 6'h2e;
   localparam logic [5:0] LRMD_IDX_C = 6'h30;
   localparam logic [5:0] LRMD_IDX_E = 6'h38;

   typedef struct packed {
      logic write;
      logic from_pci;
      logic cache_hit;
      logic [19:0] addr;
   } lrmd_acc_t;

   typedef struct packed {
      logic in_window;
      logic local_mem;
      logic to_pci_master;
      logic to_gfx;
      logic cacheable;
      logic pci_denied;
      logic cache_update;
   } lrmd_route_t;

   typedef struct packed {
      logic pipe_dis;
      logic gfx_nw;
      logic biu_nw;
   } lrmd_timing_t;
endpackage : lrmd_pkg

//--- src/lrmd_region_lookup.sv
// picks the governing region control field and graphics steering for an address
`timescale 1ns/1ns
module lrmd_region_lookup
   import lrmd_pkg::*;
(
   input wire logic [31:0] map_ab,
   input wire logic [31:0] map_cd,
   input wire logic [31:0] map_ef,
   input wire logic [5:0] idx,
   output logic [3:0] field,
   output logic gfx,
   output logic in_window
);
   logic [LRMD_FIELD_W-1:0] upper [0:2*LRMD_FIELDS_PER_REG-1];
   logic [5:0] rel;

   // ------------------------------------------------------------------
   // unpack the C..F fields in ascending address order
   // ------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < LRMD_FIELDS_PER_REG; g++) begin : g_unpack
         assign upper[g] = map_cd[g*LRMD_FIELD_W +: LRMD_FIELD_W];
         assign upper[g+LRMD_FIELDS_PER_REG] = map_ef[g*LRMD_FIELD_W +: LRMD_FIELD_W];
      end
   endgenerate

   assign rel = idx - LRMD_IDX_C;

   always_comb begin
      field = '0;
      gfx = 1'b0;
      in_window = 1'b1;
      if (idx >= LRMD_IDX_C) begin
         field = upper[rel[3:0]];
      end else if (idx >= LRMD_IDX_B_HIGH) begin
         field = map_ab[LRMD_LSB_CTL_B_HIGH +: LRMD_FIELD_W];
         gfx = map_ab[LRMD_BIT_GFX_B_HIGH];
      end else if (idx >= LRMD_IDX_B_LOW) begin
         field = map_ab[LRMD_LSB_CTL_B_LOW +: LRMD_FIELD_W];
         gfx = map_ab[LRMD_BIT_GFX_B_LOW];
      end else if (idx >= LRMD_IDX_A) begin
         field = map_ab[LRMD_LSB_CTL_A +: LRMD_FIELD_W];
         gfx = map_ab[LRMD_BIT_GFX_A];
      end else begin
         in_window = 1'b0;
      end
   end
endmodule : lrmd_region_lookup

//--- src/lrmd_top.sv
// legacy region map registers, access routing and internal-bus timing
`timescale 1ns/1ns
module lrmd_top
   import lrmd_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic REG_SEL,
   input wire logic REG_WRITE,
   input wire logic [15:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   output logic [31:0] REG_RDATA,
   output logic REG_HIT,
   input wire logic ACC_VALID,
   input wire lrmd_acc_t ACC,
   output logic RT_VALID,
   output lrmd_route_t RT,
   output logic [3:0] RT_FIELD,
   input wire logic XB_START,
   input wire logic XB_SRC_GFX,
   output logic XB_TAKE,
   output logic XB_DATA_DRIVE,
   output logic INTERNAL_DATA_STROBE,
   output logic XB_RDY
);
   logic [31:0] region_map_a_b;
   logic [31:0] region_map_c_d;
   logic [31:0] region_map_e_f;
   logic sel_ab;
   logic sel_cd;
   logic sel_ef;
   lrmd_timing_t tim;
   logic [3:0] field;
   logic gfx_hit;
   logic in_window;
   lrmd_route_t next_route;

   // ------------------------------------------------------------------
   // register port
   // ------------------------------------------------------------------
   assign sel_ab = REG_SEL && REG_ADDR == LRMD_OFF_MAP_AB;
   assign sel_cd = REG_SEL && REG_ADDR == LRMD_OFF_MAP_CD;
   assign sel_ef = REG_SEL && REG_ADDR == LRMD_OFF_MAP_EF;

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         region_map_a_b <= LRMD_RST_MAP_AB;
      end else if (sel_ab && REG_WRITE) begin
         region_map_a_b <= REG_WDATA & LRMD_MASK_MAP_AB;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         region_map_c_d <= LRMD_RST_MAP_CD;
      end else if (sel_cd && REG_WRITE) begin
         region_map_c_d <= REG_WDATA;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         region_map_e_f <= LRMD_RST_MAP_EF;
      end else if (sel_ef && REG_WRITE) begin
         region_map_e_f <= REG_WDATA;
      end
   end

   // read data is registered; unmapped offsets read zero
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         REG_RDATA <= '0;
         REG_HIT <= 1'b0;
      end else begin
         REG_HIT <= sel_ab || sel_cd || sel_ef;
         if (sel_ab) begin
            REG_RDATA <= region_map_a_b;
         end else if (sel_cd) begin
            REG_RDATA <= region_map_c_d;
         end else if (sel_ef) begin
            REG_RDATA <= region_map_e_f;
         end else begin
            REG_RDATA <= '0;
         end
      end
   end

   // ------------------------------------------------------------------
   // region lookup
   // ------------------------------------------------------------------
   lrmd_region_lookup u_lookup (
      .map_ab(region_map_a_b),
      .map_cd(region_map_c_d),
      .map_ef(region_map_e_f),
      .idx(ACC.addr[19:LRMD_IDX_LSB]),
      .field(field),
      .gfx(gfx_hit),
      .in_window(in_window)
   );

   // ------------------------------------------------------------------
   // access routing
   // ------------------------------------------------------------------
   always_comb begin
      next_route = '0;
      next_route.in_window = in_window;
      if (!in_window) begin
         next_route.local_mem = 1'b1;
         next_route.cacheable = 1'b1;
         next_route.cache_update = ACC.write && ACC.cache_hit;
      end else if (gfx_hit) begin
         next_route.to_gfx = 1'b1;
      end else if (ACC.from_pci) begin
         // slave access needs the pci bit and the matching enable
         if (field[LRMD_CTL_PCI] &&
             (ACC.write ? field[LRMD_CTL_WR] : field[LRMD_CTL_RD])) begin
            next_route.local_mem = 1'b1;
         end else begin
            next_route.pci_denied = 1'b1;
         end
      end else begin
         next_route.cacheable = field[LRMD_CTL_CACHE];
         if (ACC.write) begin
            next_route.local_mem = field[LRMD_CTL_WR];
            next_route.to_pci_master = !field[LRMD_CTL_WR];
            // cache sees the write before the permission check
            next_route.cache_update = field[LRMD_CTL_CACHE] && ACC.cache_hit;
         end else begin
            next_route.local_mem = field[LRMD_CTL_RD];
            next_route.to_pci_master = !field[LRMD_CTL_RD];
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         RT_VALID <= 1'b0;
      end else begin
         RT_VALID <= ACC_VALID;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         RT <= '0;
         RT_FIELD <= '0;
      end else if (ACC_VALID) begin
         RT <= next_route;
         RT_FIELD <= field;
      end
   end

   // ------------------------------------------------------------------
   // internal-bus timing
   // ------------------------------------------------------------------
   assign tim.pipe_dis = region_map_a_b[LRMD_BIT_PIPE_DIS];
   assign tim.gfx_nw = region_map_a_b[LRMD_BIT_GFX_NW];
   assign tim.biu_nw = region_map_a_b[LRMD_BIT_BIU_NW];

   lrmd_xbus_seq u_seq (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .tim(tim),
      .start(XB_START),
      .src_gfx(XB_SRC_GFX),
      .take(XB_TAKE),
      .data_drive(XB_DATA_DRIVE),
      .strobe(INTERNAL_DATA_STROBE),
      .rdy(XB_RDY)
   );

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   a_pci_grant: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ACC_VALID && ACC.from_pci && in_window && !gfx_hit |=>
      RT.local_mem == (RT_FIELD[LRMD_CTL_PCI] &&
      ($past(ACC.write) ? RT_FIELD[LRMD_CTL_WR] : RT_FIELD[LRMD_CTL_RD])))
      else $error("pci slave grant does not match region field");
   a_no_cache: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      RT_VALID && RT.in_window && !RT_FIELD[LRMD_CTL_CACHE] |-> !RT.cacheable)
      else $error("uncacheable region marked cacheable");
   a_write_fwd: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ACC_VALID && ACC.write && !ACC.from_pci && in_window && !gfx_hit |=>
      RT.to_pci_master == !RT_FIELD[LRMD_CTL_WR])
      else $error("write forwarding wrong");
   a_read_fwd: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ACC_VALID && !ACC.write && !ACC.from_pci && in_window && !gfx_hit |=>
      RT.to_pci_master == !RT_FIELD[LRMD_CTL_RD])
      else $error("read forwarding wrong");
   a_cache_upd: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ACC_VALID && ACC.write && ACC.cache_hit && !ACC.from_pci && in_window &&
      !gfx_hit && field[LRMD_CTL_CACHE] |=> RT.cache_update)
      else $error("cached write did not update cache");
   a_gfx_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ACC_VALID && ACC.addr[19:16] == LRMD_IDX_A[5:2] &&
      region_map_a_b[LRMD_BIT_GFX_A] |=> RT.to_gfx && !RT.local_mem)
      else $error("a region not steered to graphics");
   a_gfx_b_high: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ACC_VALID && ACC.addr[19:LRMD_IDX_LSB+1] == LRMD_IDX_B_HIGH[5:1] &&
      !region_map_a_b[LRMD_BIT_GFX_B_HIGH] |=> !RT.to_gfx)
      else $error("b high region steered while disabled");
   a_field_c0: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ACC_VALID && ACC.addr[19:LRMD_IDX_LSB] == LRMD_IDX_C |=>
      RT_FIELD == $past(region_map_c_d[LRMD_FIELD_W-1:0]))
      else $error("c0000h field select wrong");
   a_field_fc: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ACC_VALID && ACC.addr[19:LRMD_IDX_LSB] == 6'h3f |=>
      RT_FIELD == $past(region_map_e_f[31:28]))
      else $error("fc000h field select wrong");

   // ------------------------------------------------------------------
   // field selection, window, steering and routing checks
   // ------------------------------------------------------------------
   a_field_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ACC_VALID && ACC.addr[19:16] == LRMD_IDX_A[5:2] |=>
      RT_FIELD == $past(region_map_a_b[LRMD_LSB_CTL_A +: LRMD_FIELD_W]))
      else $error("a0000h field select wrong");
   a_field_b_low: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ACC_VALID && ACC.addr[19:LRMD_IDX_LSB+1] == LRMD_IDX_B_LOW[5:1] |=>
      RT_FIELD == $past(region_map_a_b[LRMD_LSB_CTL_B_LOW +: LRMD_FIELD_W]))
      else $error("b0000h field select wrong");
   a_field_b_high: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ACC_VALID && ACC.addr[19:LRMD_IDX_LSB+1] == LRMD_IDX_B_HIGH[5:1] |=>
      RT_FIELD == $past(region_map_a_b[LRMD_LSB_CTL_B_HIGH +: LRMD_FIELD_W]))
      else $error("b8000h field select wrong");
   a_gfx_b_low: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ACC_VALID && ACC.addr[19:LRMD_IDX_LSB+1] == LRMD_IDX_B_LOW[5:1] &&
      region_map_a_b[LRMD_BIT_GFX_B_LOW] |=> RT.to_gfx)
      else $error("b low region not steered to graphics");
   a_gfx_a_off: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ACC_VALID && ACC.addr[19:16] == LRMD_IDX_A[5:2] &&
      !region_map_a_b[LRMD_BIT_GFX_A] |=> !RT.to_gfx)
      else $error("a region steered while disabled");
   a_gfx_wins: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ACC_VALID && gfx_hit |=> !RT.pci_denied && !RT.to_pci_master)
      else $error("steered access also routed elsewhere");
   a_field_e0: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ACC_VALID && ACC.addr[19:LRMD_IDX_LSB] == LRMD_IDX_E |=>
      RT_FIELD == $past(region_map_e_f[LRMD_FIELD_W-1:0]))
      else $error("e0000h field select wrong");
   a_field_dc: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ACC_VALID && ACC.addr[19:LRMD_IDX_LSB] == 6'h37 |=>
      RT_FIELD == $past(region_map_c_d[31:28]))
      else $error("dc000h field select wrong");
   a_below_window: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ACC_VALID && ACC.addr[19:LRMD_IDX_LSB] < LRMD_IDX_A |=>
      !RT.in_window && RT.local_mem)
      else $error("low address treated as window access");
   a_in_window: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ACC_VALID && ACC.addr[19:LRMD_IDX_LSB] >= LRMD_IDX_A |=> RT.in_window)
      else $error("window access not flagged");
   a_pci_deny: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ACC_VALID && ACC.from_pci && in_window && !gfx_hit |=>
      RT.pci_denied != RT.local_mem)
      else $error("pci slave grant and deny disagree");
   a_read_local: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ACC_VALID && !ACC.write && !ACC.from_pci && in_window && !gfx_hit |=>
      RT.local_mem == RT_FIELD[LRMD_CTL_RD])
      else $error("local read enable wrong");
   a_write_local: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ACC_VALID && ACC.write && !ACC.from_pci && in_window && !gfx_hit |=>
      RT.local_mem == RT_FIELD[LRMD_CTL_WR])
      else $error("local write enable wrong");
   a_core_cache: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ACC_VALID && !ACC.from_pci && in_window && !gfx_hit |=>
      RT.cacheable == RT_FIELD[LRMD_CTL_CACHE])
      else $error("cacheable flag does not follow field");
   a_rt_pulse: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ACC_VALID |=> RT_VALID)
      else $error("lookup result not flagged valid");

   // ------------------------------------------------------------------
   // register port and bus timing checks
   // ------------------------------------------------------------------
   a_write_cd: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      REG_SEL && REG_WRITE && REG_ADDR == LRMD_OFF_MAP_CD |=>
      region_map_c_d == $past(REG_WDATA))
      else $error("c/d map write lost");
   a_write_ef: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      REG_SEL && REG_WRITE && REG_ADDR == LRMD_OFF_MAP_EF |=>
      region_map_e_f == $past(REG_WDATA))
      else $error("e/f map write lost");
   a_ab_reserved: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (region_map_a_b & ~LRMD_MASK_MAP_AB) == '0)
      else $error("reserved a/b map bits set");
   a_reg_idle: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      !REG_SEL |=> !REG_HIT && REG_RDATA == '0)
      else $error("read data without select");
   a_pipe_overlap: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      !tim.pipe_dis && XB_RDY && XB_START |-> XB_TAKE)
      else $error("overlap refused while pipelining enabled");
endmodule : lrmd_top

//--- src/lrmd_xbus_seq.sv
// internal-bus cycle sequencer: address overlap and data-drive timing
`timescale 1ns/1ns
module lrmd_xbus_seq
   import lrmd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire lrmd_timing_t tim,
   input wire logic start,
   input wire logic src_gfx,
   output logic take,
   output logic data_drive,
   output logic strobe,
   output logic rdy
);
   typedef enum logic [1:0] {S_IDLE, S_EARLY, S_XFER} lrmd_seq_t;
   lrmd_seq_t state;
   lrmd_seq_t next_state;
   logic no_wait;

   assign no_wait = src_gfx ? tim.gfx_nw : tim.biu_nw;
   // overlap only in the last data cycle, and only when pipelining is on
   assign take = start && (state == S_IDLE || (state == S_XFER && !tim.pipe_dis));

   always_comb begin
      case (state)
         S_IDLE, S_XFER: begin
            if (take) begin
               next_state = no_wait ? S_XFER : S_EARLY;
            end else begin
               next_state = S_IDLE;
            end
         end
         S_EARLY: next_state = S_XFER;
         default: next_state = S_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= S_IDLE;
      end else begin
         state <= next_state;
      end
   end

   assign data_drive = (state != S_IDLE);
   assign strobe = (state == S_XFER);
   assign rdy = (state == S_XFER);

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   sequence s_wait_take;
      take && !no_wait;
   endsequence

   sequence s_early_then_strobe;
      data_drive && !strobe ##1 strobe && rdy;
   endsequence

   a_early_drive: assert property (@(posedge clk) disable iff (!rst_n)
      s_wait_take |=> s_early_then_strobe)
      else $error("data not driven one clock before strobe");
   a_nowait_drive: assert property (@(posedge clk) disable iff (!rst_n)
      take && no_wait |=> data_drive && strobe && rdy)
      else $error("no-wait data not driven with ready");
   a_no_overlap: assert property (@(posedge clk) disable iff (!rst_n)
      tim.pipe_dis && strobe |=> !data_drive)
      else $error("address overlap while pipelining disabled");
endmodule : lrmd_xbus_seq
